// [rtl/fpec_pkg.sv]
// constants, field layout and helper functions of the flash program/erase control
package fpec_pkg;

	// ==========================================================
	// register offsets
	localparam logic [3:0] OFS_MODE_CTL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_BLK_SEL = 4'h2;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

	// ==========================================================
	// mode control fields
	localparam int BIT_RSVD = 7;
	localparam int BIT_UNLOCK = 6;
	localparam int BIT_ERASE_PREP = 5;
	localparam int BIT_PROG_PREP = 4;
	localparam int BIT_ERASE_CHECK = 3;
	localparam int BIT_PROG_CHECK = 2;
	localparam int BIT_ERASE = 1;
	localparam int BIT_PROG = 0;
	localparam int BIT_FAULT = 7;
	localparam logic [6:0] CTL_RESET = 7'h00;
	localparam logic [6:0] CTL_UNLOCK_ONLY = 7'h40;
	localparam logic [4:0] BLK_RESET = 5'h00;

	// ==========================================================
	// interrupt bits
	localparam int IRQ_W = 2;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_REFUSED = 1;

	// ==========================================================
	// array geometry
	localparam int AW = 16;
	localparam int UNIT_LSB = 7;
	localparam logic [15:0] SMALL_LIMIT = 16'h0fff;
	localparam logic [15:0] ARRAY_LIMIT = 16'h4fff;
	localparam int SMALL_LSB = 10;
	localparam logic [2:0] BLK_BIG = 3'h4;
	localparam logic [2:0] BLK_NONE = 3'h7;

	// block index of an address, BLK_NONE outside the array
	function automatic logic [2:0] block_of(input logic [15:0] a);
		if (a <= SMALL_LIMIT)
			block_of = {1'b0, a[SMALL_LSB+1:SMALL_LSB]};
		else if (a <= ARRAY_LIMIT)
			block_of = BLK_BIG;
		else
			block_of = BLK_NONE;
	endfunction

	// true when more than one bit is set
	function automatic logic multi_set(input logic [4:0] v);
		multi_set = (v & (v - 5'h01)) != 5'h00;
	endfunction

endpackage

// [rtl/fpec_geom_if.sv]
// address-to-geometry carrier between control and decoder
`timescale 1ns/100ps
interface fpec_geom_if;
	logic [15:0] addr;
	logic [15:0] unit_base;
	logic [2:0] block_idx;
	logic in_array;
	modport req (output addr, input unit_base, input block_idx, input in_array);
	modport geo (input addr, output unit_base, output block_idx, output in_array);
endinterface

// [rtl/fpec_geom.sv]
// flash array geometry decoder
`timescale 1ns/100ps
module fpec_geom (
	fpec_geom_if.geo g
);
	// ==========================================================
	// decode
	wire [2:0] blk_w = fpec_pkg::block_of(g.addr);
	assign g.block_idx = blk_w;
	assign g.in_array = blk_w != fpec_pkg::BLK_NONE;
	// low seven bits cleared gives a 00 or 80 boundary
	assign g.unit_base = {g.addr[15:fpec_pkg::UNIT_LSB], 7'h00};
endmodule

// [rtl/fpec_top.sv]
// flash program/erase control: registers, interlocks, fault and interrupt
`timescale 1ns/100ps
module fpec_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] arr_addr,
	input wire logic arr_wr,
	input wire logic arr_fail,
	output logic read_mode,
	output logic prog_mode,
	output logic erase_mode,
	output logic prog_prep_state,
	output logic erase_prep_state,
	output logic prog_check_mode,
	output logic erase_check_mode,
	output logic [4:0] erase_blocks,
	output logic prog_wr,
	output logic [15:0] prog_addr,
	output logic [15:0] prog_unit,
	output logic fault,
	output logic irq
);
	// ==========================================================
	// geometry decoder
	fpec_geom_if gif ();
	assign gif.addr = arr_addr;
	fpec_geom u_geom (
		.g(gif.geo)
	);

	// ==========================================================
	// state
	logic [6:0] ctl_ff;
	logic [4:0] blk_ff;
	logic fault_ff;
	logic [1:0] irq_st_ff;
	logic [1:0] irq_mask_ff;
	logic [7:0] rdata_ff;
	logic fail_s1_ff;
	logic fail_s2_ff;
	logic fail_s3_ff;
	logic unit_valid_ff;
	logic [15:0] unit_ff;
	logic read_mode_ff;
	logic prog_mode_ff;
	logic erase_mode_ff;
	logic pprep_ff;
	logic eprep_ff;
	logic pcheck_ff;
	logic echeck_ff;
	logic [4:0] eblk_ff;
	logic prog_wr_ff;
	logic [15:0] prog_addr_ff;
	logic irq_ff;

	// ==========================================================
	// register decode
	wire wr_ctl = reg_wr && (reg_addr == fpec_pkg::OFS_MODE_CTL);
	wire wr_blk = reg_wr && (reg_addr == fpec_pkg::OFS_BLK_SEL);
	wire wr_ist = reg_wr && (reg_addr == fpec_pkg::OFS_IRQ_STAT);
	wire wr_imsk = reg_wr && (reg_addr == fpec_pkg::OFS_IRQ_MASK);
	wire unlocked = ctl_ff[fpec_pkg::BIT_UNLOCK];
	wire wr_unlock = reg_wdata[fpec_pkg::BIT_UNLOCK];

	// ==========================================================
	// mode control update
	// other bits take effect only once unlock is already set, so a
	// single write cannot both unlock and start an operation
	wire [6:0] ctl_written = !wr_unlock ? fpec_pkg::CTL_RESET :
		unlocked ? reg_wdata[6:0] : fpec_pkg::CTL_UNLOCK_ONLY;
	wire [6:0] nxt_ctl = wr_ctl ? ctl_written : ctl_ff;
	wire ctl_refused = wr_ctl && (reg_wdata[5:0] != 6'h00) && !(unlocked && wr_unlock);

	// ==========================================================
	// block select update
	wire [4:0] blk_written = (!unlocked || fpec_pkg::multi_set(reg_wdata[4:0])) ?
		fpec_pkg::BLK_RESET : reg_wdata[4:0];
	wire [4:0] blk_kept = wr_blk ? blk_written : blk_ff;
	wire [4:0] nxt_blk = nxt_ctl[fpec_pkg::BIT_UNLOCK] ? blk_kept : fpec_pkg::BLK_RESET;
	wire blk_refused = wr_blk && !unlocked && (reg_wdata[4:0] != 5'h00);

	// ==========================================================
	// array writes in program mode
	wire prog_try = arr_wr && prog_mode_ff;
	wire unit_hit = !unit_valid_ff || (gif.unit_base == unit_ff);
	wire prog_take = prog_try && gif.in_array && unit_hit;
	wire prog_outside = prog_try && !gif.in_array;
	wire prog_off_unit = prog_try && gif.in_array && !unit_hit;
	wire nxt_unit_valid = prog_mode_ff && (unit_valid_ff || prog_take);
	wire [15:0] nxt_unit = (prog_take && !unit_valid_ff) ? gif.unit_base : unit_ff;

	// ==========================================================
	// fault and interrupts
	wire fail_rise = fail_s2_ff && !fail_s3_ff;
	wire fault_event = (fail_rise || prog_outside) && !fault_ff;
	wire nxt_fault = fault_ff || fail_rise || prog_outside;
	wire [1:0] irq_ev = {ctl_refused || blk_refused || prog_off_unit, fault_event};
	wire [1:0] irq_clr = wr_ist ? reg_wdata[1:0] : 2'h0;
	wire [1:0] nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;
	wire [1:0] nxt_irq_mask = wr_imsk ? reg_wdata[1:0] : irq_mask_ff;

	// ==========================================================
	// effective modes
	wire nxt_prog = nxt_ctl[fpec_pkg::BIT_PROG] && nxt_ctl[fpec_pkg::BIT_UNLOCK] &&
		nxt_ctl[fpec_pkg::BIT_PROG_PREP] && !nxt_fault;
	wire nxt_erase = nxt_ctl[fpec_pkg::BIT_ERASE] && nxt_ctl[fpec_pkg::BIT_UNLOCK] &&
		nxt_ctl[fpec_pkg::BIT_ERASE_PREP] && !nxt_fault;
	wire nxt_read = nxt_ctl[5:0] == 6'h00;

	// ==========================================================
	// read mux
	wire [7:0] rd_ctl = {1'b0, ctl_ff};
	wire [7:0] rd_stat = {fault_ff, 7'h00};
	wire [7:0] rd_sel = (reg_addr == fpec_pkg::OFS_MODE_CTL) ? rd_ctl :
		(reg_addr == fpec_pkg::OFS_STATUS) ? rd_stat :
		(reg_addr == fpec_pkg::OFS_BLK_SEL) ? {3'h0, blk_ff} :
		(reg_addr == fpec_pkg::OFS_IRQ_STAT) ? {6'h00, irq_st_ff} :
		(reg_addr == fpec_pkg::OFS_IRQ_MASK) ? {6'h00, irq_mask_ff} : 8'h00;

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_ff <= fpec_pkg::CTL_RESET;
			blk_ff <= fpec_pkg::BLK_RESET;
			fault_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			blk_ff <= nxt_blk;
			fault_ff <= nxt_fault;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_st_ff <= 2'h0;
			irq_mask_ff <= 2'h0;
			irq_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			irq_st_ff <= nxt_irq_st;
			irq_mask_ff <= nxt_irq_mask;
			irq_ff <= (nxt_irq_st & nxt_irq_mask) != 2'h0;
			rdata_ff <= reg_rd ? rd_sel : 8'h00;
		end
	end

	// fail pin comes from the array's own timing, so it is synchronised
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fail_s1_ff <= 1'b0;
			fail_s2_ff <= 1'b0;
			fail_s3_ff <= 1'b0;
		end else begin
			fail_s1_ff <= arr_fail;
			fail_s2_ff <= fail_s1_ff;
			fail_s3_ff <= fail_s2_ff;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			read_mode_ff <= 1'b1;
			prog_mode_ff <= 1'b0;
			erase_mode_ff <= 1'b0;
			pprep_ff <= 1'b0;
			eprep_ff <= 1'b0;
			pcheck_ff <= 1'b0;
			echeck_ff <= 1'b0;
			eblk_ff <= 5'h00;
		end else begin
			read_mode_ff <= nxt_read;
			prog_mode_ff <= nxt_prog;
			erase_mode_ff <= nxt_erase;
			pprep_ff <= nxt_ctl[fpec_pkg::BIT_PROG_PREP];
			eprep_ff <= nxt_ctl[fpec_pkg::BIT_ERASE_PREP];
			pcheck_ff <= nxt_ctl[fpec_pkg::BIT_PROG_CHECK];
			echeck_ff <= nxt_ctl[fpec_pkg::BIT_ERASE_CHECK];
			eblk_ff <= nxt_erase ? nxt_blk : 5'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unit_valid_ff <= 1'b0;
			unit_ff <= 16'h0000;
			prog_wr_ff <= 1'b0;
			prog_addr_ff <= 16'h0000;
		end else begin
			unit_valid_ff <= nxt_unit_valid;
			unit_ff <= nxt_unit;
			prog_wr_ff <= prog_take;
			prog_addr_ff <= prog_take ? arr_addr : prog_addr_ff;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = rdata_ff;
	assign read_mode = read_mode_ff;
	assign prog_mode = prog_mode_ff;
	assign erase_mode = erase_mode_ff;
	assign prog_prep_state = pprep_ff;
	assign erase_prep_state = eprep_ff;
	assign prog_check_mode = pcheck_ff;
	assign erase_check_mode = echeck_ff;
	assign erase_blocks = eblk_ff;
	assign prog_wr = prog_wr_ff;
	assign prog_addr = prog_addr_ff;
	assign prog_unit = unit_ff;
	assign fault = fault_ff;
	assign irq = irq_ff;

	// ==========================================================
	// checks
	chk_prog_interlock: assert property (@(posedge clk) disable iff (!resetn)
		prog_mode_ff |-> (ctl_ff[6] && ctl_ff[4] && ctl_ff[0] && !fault_ff))
		else $error("program mode without unlock and prep");

	chk_erase_interlock: assert property (@(posedge clk) disable iff (!resetn)
		erase_mode_ff |-> (ctl_ff[6] && ctl_ff[5] && ctl_ff[1] && !fault_ff))
		else $error("erase mode without unlock and prep");

	chk_lock_clears: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !reg_wdata[6]) |=> (ctl_ff == 7'h00 && blk_ff == 5'h00))
		else $error("clearing unlock left bits set");

	chk_blk_single: assert property (@(posedge clk) disable iff (!resetn)
		(wr_blk && $countones(reg_wdata[4:0]) > 1) |=> blk_ff == 5'h00)
		else $error("multiple block select not cleared");

	chk_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
		(reg_rd && reg_addr == 4'h0) |=> (reg_rdata[7] == 1'b0 && reg_rdata[6:0] == ctl_ff))
		else $error("mode control readback wrong");

	chk_fault_protect: assert property (@(posedge clk) disable iff (!resetn)
		$rose(fault_ff) |-> (!prog_mode_ff && !erase_mode_ff)[*3])
		else $error("array active under fault");

	chk_unit_align: assert property (@(posedge clk) disable iff (!resetn)
		prog_wr_ff |-> (prog_unit[6:0] == 7'h00 && prog_addr[15:7] == prog_unit[15:7]))
		else $error("program write outside unit");

	chk_read_mode: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !reg_wdata[6]) |=> read_mode_ff && !pprep_ff && !eprep_ff)
		else $error("read mode not restored");

	chk_erase_blocks: assert property (@(posedge clk) disable iff (!resetn)
		erase_mode_ff |-> (erase_blocks == $past(nxt_blk) && $countones(erase_blocks) <= 1))
		else $error("erase blocks wrong");

	chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
		irq_ff == ((irq_st_ff & irq_mask_ff) != 2'h0))
		else $error("interrupt level wrong");

	// ==========================================================
	// interlock, refusal and fault checks
	chk_unlock_only: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && wr_unlock && !unlocked) |=> ctl_ff == fpec_pkg::CTL_UNLOCK_ONLY)
		else $error("locked write set more than unlock");

	chk_locked_refused: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !unlocked && reg_wdata[5:0] != 6'h00) |=> irq_st_ff[fpec_pkg::IRQ_REFUSED])
		else $error("refused mode write not flagged");

	chk_ctl_locked: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !unlocked) |=> ctl_ff[5:0] == 6'h00)
		else $error("mode bit set while locked");

	chk_blk_locked: assert property (@(posedge clk) disable iff (!resetn)
		!ctl_ff[fpec_pkg::BIT_UNLOCK] |-> blk_ff == fpec_pkg::BLK_RESET)
		else $error("block select kept while locked");

	chk_blk_store: assert property (@(posedge clk) disable iff (!resetn)
		(wr_blk && unlocked && $countones(reg_wdata[4:0]) == 1) |=>
		blk_ff == $past(reg_wdata[4:0]))
		else $error("single block select not stored");

	chk_eprep_bit: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && unlocked && wr_unlock) |=>
		erase_prep_state == $past(reg_wdata[fpec_pkg::BIT_ERASE_PREP]))
		else $error("erase setup state wrong");

	chk_pprep_bit: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && unlocked && wr_unlock) |=>
		prog_prep_state == $past(reg_wdata[fpec_pkg::BIT_PROG_PREP]))
		else $error("program setup state wrong");

	chk_echeck_bit: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && unlocked && wr_unlock) |=>
		erase_check_mode == $past(reg_wdata[fpec_pkg::BIT_ERASE_CHECK]))
		else $error("erase verify mode wrong");

	chk_pcheck_bit: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && unlocked && wr_unlock) |=>
		prog_check_mode == $past(reg_wdata[fpec_pkg::BIT_PROG_CHECK]))
		else $error("program verify mode wrong");

	chk_erase_cancel: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !reg_wdata[fpec_pkg::BIT_ERASE]) |=> !erase_mode_ff)
		else $error("erase mode not cancelled");

	chk_prog_cancel: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !reg_wdata[fpec_pkg::BIT_PROG]) |=> !prog_mode_ff)
		else $error("program mode not cancelled");

	chk_read_exact: assert property (@(posedge clk) disable iff (!resetn)
		read_mode_ff == (ctl_ff[5:0] == 6'h00))
		else $error("read mode disagrees with mode bits");

	chk_fault_sticky: assert property (@(posedge clk) disable iff (!resetn)
		fault_ff |=> fault_ff)
		else $error("fault flag dropped without reset");

	chk_fault_pin: assert property (@(posedge clk) disable iff (!resetn)
		(fail_s2_ff && !fail_s3_ff) |=> fault_ff)
		else $error("array failure not flagged");

	chk_fault_outside: assert property (@(posedge clk) disable iff (!resetn)
		(arr_wr && prog_mode_ff && arr_addr > fpec_pkg::ARRAY_LIMIT) |=> fault_ff)
		else $error("write beyond array not flagged");

	chk_fault_no_write: assert property (@(posedge clk) disable iff (!resetn)
		fault_ff |=> !prog_wr_ff)
		else $error("program write under fault");

	chk_unit_hold: assert property (@(posedge clk) disable iff (!resetn)
		unit_valid_ff |=> prog_unit == $past(prog_unit))
		else $error("program unit moved");

	chk_off_unit: assert property (@(posedge clk) disable iff (!resetn)
		(arr_wr && prog_mode_ff && unit_valid_ff && arr_addr <= fpec_pkg::ARRAY_LIMIT &&
		arr_addr[15:7] != unit_ff[15:7]) |=> (!prog_wr_ff && irq_st_ff[fpec_pkg::IRQ_REFUSED]))
		else $error("off-unit write accepted");

	chk_status_read: assert property (@(posedge clk) disable iff (!resetn)
		(reg_rd && reg_addr == fpec_pkg::OFS_STATUS) |=> reg_rdata == {$past(fault_ff), 7'h00})
		else $error("status readback wrong");

	chk_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read strobe");
endmodule

// [bench/tb.sv]
// self-checking bench for the flash program/erase control
`timescale 1ns/100ps
module tb;
	logic clk, resetn, reg_wr, reg_rd, arr_wr, arr_fail;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [15:0] arr_addr;
	logic [7:0] reg_rdata;
	logic read_mode, prog_mode, erase_mode, prog_prep_state, erase_prep_state;
	logic prog_check_mode, erase_check_mode, prog_wr, fault, irq;
	logic [4:0] erase_blocks;
	logic [15:0] prog_addr, prog_unit;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	fpec_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_addr(arr_addr),
		.arr_wr(arr_wr), .arr_fail(arr_fail), .read_mode(read_mode), .prog_mode(prog_mode),
		.erase_mode(erase_mode), .prog_prep_state(prog_prep_state),
		.erase_prep_state(erase_prep_state), .prog_check_mode(prog_check_mode),
		.erase_check_mode(erase_check_mode), .erase_blocks(erase_blocks), .prog_wr(prog_wr),
		.prog_addr(prog_addr), .prog_unit(prog_unit), .fault(fault), .irq(irq));
	// ==========================================================
	// clock, timeout and report
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ceiling far above the hundred-odd cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ==========================================================
	// bus drivers
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_val({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	task automatic aw(input logic [15:0] a);
		@(posedge clk);
		arr_addr <= a;
		arr_wr <= 1'b1;
		@(posedge clk);
		arr_wr <= 1'b0;
		#1;
	endtask
	task automatic wait_fault(input int n);
		for (int i = 0; i < n; i++) begin
			if (fault === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk_bit(read_mode, 1'b1);
		chk_val({prog_mode, erase_mode, fault, irq, erase_blocks}, 9'h000);
		rd_chk(fpec_pkg::OFS_MODE_CTL, 8'h00);
		rd_chk(fpec_pkg::OFS_BLK_SEL, 8'h00);
	endtask
	task automatic t_locked();
		wr(fpec_pkg::OFS_BLK_SEL, 8'h01);
		rd_chk(fpec_pkg::OFS_BLK_SEL, 8'h00);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h7f);
		chk_bit(prog_mode, 1'b0);
		rd_chk(fpec_pkg::OFS_MODE_CTL, 8'h40);
		rd_chk(fpec_pkg::OFS_IRQ_STAT, 8'h02);
		wr(fpec_pkg::OFS_IRQ_MASK, 8'h02);
		chk_bit(irq, 1'b1);
		wr(fpec_pkg::OFS_IRQ_STAT, 8'h02);
		chk_bit(irq, 1'b0);
		wr(fpec_pkg::OFS_MODE_CTL, 8'hc0);
		rd_chk(fpec_pkg::OFS_MODE_CTL, 8'h40);
		wr(fpec_pkg::OFS_STATUS, 8'hff);
		rd_chk(fpec_pkg::OFS_STATUS, 8'h00);
		rd_chk(4'hf, 8'h00);
	endtask
	task automatic t_modes();
		logic [7:0] tbl [4] = '{8'h48, 8'h44, 8'h60, 8'h50};
		foreach (tbl[i]) begin
			wr(fpec_pkg::OFS_MODE_CTL, tbl[i]);
			chk_val({erase_prep_state, prog_prep_state, erase_check_mode, prog_check_mode},
				{12'h000, tbl[i][5:2]});
			chk_bit(read_mode, 1'b0);
		end
		wr(fpec_pkg::OFS_MODE_CTL, 8'h40);
		chk_bit(read_mode, 1'b1);
	endtask
	task automatic t_prog();
		wr(fpec_pkg::OFS_MODE_CTL, 8'h41);
		chk_bit(prog_mode, 1'b0);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h50);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h51);
		chk_bit(prog_mode, 1'b1);
		aw(16'h01a5);
		chk_bit(prog_wr, 1'b1);
		chk_val(prog_addr, 16'h01a5);
		chk_val(prog_unit, 16'h0180);
		aw(16'h01ff);
		chk_bit(prog_wr, 1'b1);
		aw(16'h0200);
		chk_bit(prog_wr, 1'b0);
		rd_chk(fpec_pkg::OFS_IRQ_STAT, 8'h02);
		wr(fpec_pkg::OFS_IRQ_STAT, 8'h02);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h50);
		chk_bit(prog_mode, 1'b0);
	endtask
	task automatic t_erase();
		wr(fpec_pkg::OFS_MODE_CTL, 8'h60);
		wr(fpec_pkg::OFS_BLK_SEL, 8'h10);
		chk_val({11'h000, erase_blocks}, 16'h0000);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h62);
		chk_bit(erase_mode, 1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(fpec_pkg::OFS_BLK_SEL, 8'h01 << i);
			@(posedge clk);
			#1;
			chk_val({11'h000, erase_blocks}, 16'h0001 << i);
		end
		wr(fpec_pkg::OFS_BLK_SEL, 8'h03);
		rd_chk(fpec_pkg::OFS_BLK_SEL, 8'h00);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h42);
		chk_bit(erase_mode, 1'b0);
		wr(fpec_pkg::OFS_BLK_SEL, 8'h04);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h00);
		rd_chk(fpec_pkg::OFS_BLK_SEL, 8'h00);
	endtask
	task automatic t_fault();
		wr(fpec_pkg::OFS_MODE_CTL, 8'h40);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h50);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h51);
		wr(fpec_pkg::OFS_IRQ_MASK, 8'h01);
		@(posedge clk);
		arr_fail <= 1'b1;
		wait_fault(8);
		chk_bit(fault, 1'b1);
		chk_bit(prog_mode, 1'b0);
		chk_bit(irq, 1'b1);
		rd_chk(fpec_pkg::OFS_STATUS, 8'h80);
		wr(fpec_pkg::OFS_IRQ_STAT, 8'h01);
		chk_bit(irq, 1'b0);
		aw(16'h0100);
		chk_bit(prog_wr, 1'b0);
	endtask
	// fault is reset-only, so a mid-run reset precedes the out-of-array write
	task automatic t_outside();
		@(posedge clk);
		resetn <= 1'b0;
		arr_fail <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk_bit(fault, 1'b0);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h40);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h50);
		wr(fpec_pkg::OFS_MODE_CTL, 8'h51);
		aw(16'h5000);
		chk_bit(prog_wr, 1'b0);
		wait_fault(4);
		chk_bit(fault, 1'b1);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		arr_wr = 1'b0;
		arr_fail = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		arr_addr = 16'h0000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		#1;
		t_reset();
		t_locked();
		t_modes();
		t_prog();
		t_erase();
		t_fault();
		t_outside();
		finish_test();
	end
endmodule
